// [inc/mwp_pkg.sv]
package mwp_pkg;

	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [31:0] MWP_OFF_CFG_SECOND = 32'h8000_0004;
	localparam logic [31:0] MWP_OFF_CFG_THIRD  = 32'h8000_0008;
	localparam logic [31:0] MWP_OFF_TAGMASK1   = 32'h8000_001c;
	localparam logic [31:0] MWP_OFF_TAGMASK2   = 32'h8000_0020;
	localparam logic [31:0] MWP_OFF_SEG1_START = 32'h8000_00d0;
	localparam logic [31:0] MWP_OFF_SEG1_END   = 32'h8000_00d4;
	localparam logic [31:0] MWP_OFF_SEG2_START = 32'h8000_00d8;
	localparam logic [31:0] MWP_OFF_SEG2_END   = 32'h8000_00dc;

	// ****************************************
	// field positions
	// ****************************************
	localparam int MWP_CF2_REFRESH_BIT = 31;
	localparam int MWP_CF2_RMW_BIT     = 6;
	localparam int MWP_CF3_RFC_LO      = 30;
	localparam int MWP_CF3_PRESENT_BIT = 27;
	localparam int MWP_CF3_RELOAD_LO   = 12;
	localparam int MWP_CF3_WB_BIT      = 11;
	localparam int MWP_CF3_RB_BIT      = 10;
	localparam int MWP_CF3_RE_BIT      = 9;
	localparam int MWP_CF3_PE_BIT      = 8;
	localparam int MWP_TCB_W           = 8;
	localparam int MWP_RELOAD_W        = 15;
	localparam int MWP_UNITS           = 2;

	// ****************************************
	// constant and reset values
	// ****************************************
	localparam logic [1:0]              MWP_RFC_SEVEN   = 2'h3;
	localparam logic [MWP_RELOAD_W-1:0] MWP_RELOAD_RST  = 15'h7fff;
	localparam logic [MWP_TCB_W-1:0]    MWP_TCB_RST     = 8'h00;
	localparam logic [1:0]              MWP_RESP_OKAY   = 2'h0;
	localparam logic [1:0]              MWP_RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		MWP_REG_NONE = 4'h0, MWP_REG_CF2 = 4'h1, MWP_REG_CF3 = 4'h2,
		MWP_REG_TM1  = 4'h3, MWP_REG_TM2 = 4'h4, MWP_REG_S1A = 4'h5,
		MWP_REG_S1B  = 4'h6, MWP_REG_S2A = 4'h7, MWP_REG_S2B = 4'h8
	} mwp_reg_e;

	// tag/mask unit, laid out exactly as its register word
	typedef struct packed {
		logic        en;
		logic        block_guard_select;
		logic [14:0] tag;
		logic [14:0] mask;
	} mwp_tagmask_s;

	typedef struct packed {
		logic [27:0] first;
		logic [27:0] last;
		logic        block_guard_select;
		logic        unprivileged_guard;
		logic        privileged_guard;
	} mwp_seg_s;

	// one processor memory access
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        privilege_state_bit;
		logic        prom;
		logic [31:0] addr;
	} mwp_acc_s;

endpackage

// [hw/mwp_guard.sv]
`timescale 1ns/1ns
// Functional notes
// - third config register bits 31:30 read constant 11: seven register-file checkbits.
// - bit 27 reads whether memory checking hardware is present.
// - refresh counter reloads from field; refreshes spaced reload plus one clocks.
// - write-bypass set: stores write the test checkbits instead of computed ones.
// - read-capture set: fetches and loads copy memory checkbits into test field.
// - RAM checking enable protects RAM and turns on SDRAM sub-word read-modify-write.
// - PROM checking enable protects PROM; loaded at reset from strap pin.
// - test checkbits: eight read/write bits 7:0 of third config register.
// - tag/mask unit checks writes only while its bit 31 enable is set.
// - tag/mask bit 30: set block-protect, clear segment-allow.
// - tag bits 29:15 XORed with matching write-address bits.
// - mask bits 14:0 select which XOR result bits take part.
// - segment start holds word address 29:2, start included.
// - segment end holds word address 29:2, end included.
// - end bit 1 enables segment check for user mode accesses.
// - end bit 0 enables segment check for supervisor mode accesses.
// - start bit 1: set block-protect, clear segment-allow.
// - second config bit 6 enables SRAM sub-word read-modify-write.
// - second config bit 31 gates periodic auto-refresh.
module mwp_guard
	import mwp_pkg::*;
#(
	parameter logic CHECK_PRESENT = 1'b1
)(
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	input  wire logic [31:0]           S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	output logic [1:0]                 S_AXI_BRESP,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	input  wire logic [31:0]           S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	input  wire mwp_acc_s              ACC,
	input  wire logic [MWP_TCB_W-1:0]  CHECK_CALC,
	input  wire logic [MWP_TCB_W-1:0]  CHECK_RD,
	input  wire logic                  PROM_EDAC_STRAP,
	output logic                       ACC_DONE,
	output logic                       ACC_ERROR,
	output logic                       MEM_WE,
	output logic [MWP_TCB_W-1:0]       CHECK_WR,
	output logic                       CHECK_EN,
	output logic                       RAM_EDAC_EN,
	output logic                       PROM_EDAC_EN,
	output logic                       SRAM_RMW_EN,
	output logic                       SDRAM_RMW_EN,
	output logic                       REFRESH_PULSE
);

	generate
		if ($bits(CHECK_PRESENT) != 1) begin : g_bad
			$error("CHECK_PRESENT must be one bit");
		end
	endgenerate

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic mwp_reg_e reg_decode(input logic [31:0] a);
		mwp_reg_e s;
		s = MWP_REG_NONE;
		unique case (a)
			MWP_OFF_CFG_SECOND: s = MWP_REG_CF2;
			MWP_OFF_CFG_THIRD:  s = MWP_REG_CF3;
			MWP_OFF_TAGMASK1:   s = MWP_REG_TM1;
			MWP_OFF_TAGMASK2:   s = MWP_REG_TM2;
			MWP_OFF_SEG1_START: s = MWP_REG_S1A;
			MWP_OFF_SEG1_END:   s = MWP_REG_S1B;
			MWP_OFF_SEG2_START: s = MWP_REG_S2A;
			MWP_OFF_SEG2_END:   s = MWP_REG_S2B;
			default:            s = MWP_REG_NONE;
		endcase
		return s;
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return m;
	endfunction

	// ****************************************
	// register state
	// ****************************************
	logic                    refresh_en_r;
	logic                    sram_rmw_r;
	logic [MWP_RELOAD_W-1:0] reload_r;
	logic                    wb_r;
	logic                    rb_r;
	logic                    re_r;
	logic                    pe_r;
	logic [MWP_TCB_W-1:0]    tcb_r;
	logic                    strap_done_r;
	mwp_tagmask_s            tm_r  [MWP_UNITS];
	mwp_seg_s                seg_r [MWP_UNITS];

	// bus channel state
	logic                    aw_have_r;
	logic                    w_have_r;
	logic [31:0]             aw_addr_r;
	logic [31:0]             w_data_r;
	logic [3:0]              w_strb_r;
	mwp_reg_e                rd_sel_r;
	logic                    wr_fire;
	mwp_reg_e                wr_sel;
	logic [31:0]             wr_old;
	logic [31:0]             wr_word;
	logic [31:0]             cf2_word;
	logic [31:0]             cf3_word;
	logic [31:0]             rd_word;
	mwp_reg_e                rd_sel;

	// ****************************************
	// register word views
	// ****************************************
	assign cf2_word = {refresh_en_r, 24'h0, sram_rmw_r, 6'h0};
	assign cf3_word = {MWP_RFC_SEVEN, 2'h0, CHECK_PRESENT, reload_r,
		wb_r, rb_r, re_r, pe_r, tcb_r};

	function automatic logic [31:0] word_of(input mwp_reg_e s, input logic [31:0] c2,
		input logic [31:0] c3, input mwp_tagmask_s t0, input mwp_tagmask_s t1,
		input mwp_seg_s s0, input mwp_seg_s s1);
		logic [31:0] w;
		w = 32'h0;
		unique case (s)
			MWP_REG_CF2:  w = c2;
			MWP_REG_CF3:  w = c3;
			MWP_REG_TM1:  w = t0;
			MWP_REG_TM2:  w = t1;
			MWP_REG_S1A:  w = {2'h0, s0.first, s0.block_guard_select, 1'b0};
			MWP_REG_S1B:  w = {2'h0, s0.last, s0.unprivileged_guard, s0.privileged_guard};
			MWP_REG_S2A:  w = {2'h0, s1.first, s1.block_guard_select, 1'b0};
			MWP_REG_S2B:  w = {2'h0, s1.last, s1.unprivileged_guard, s1.privileged_guard};
			default:      w = 32'h0;
		endcase
		return w;
	endfunction

	// write side: merge strobed lanes into the current word
	assign wr_fire = aw_have_r & w_have_r & ~S_AXI_BVALID;
	assign wr_sel  = reg_decode(aw_addr_r);
	assign wr_old  = word_of(wr_sel, cf2_word, cf3_word, tm_r[0], tm_r[1], seg_r[0], seg_r[1]);
	assign wr_word = lane_merge(wr_old, w_data_r, w_strb_r);
	assign rd_sel  = reg_decode(S_AXI_ARADDR);
	assign rd_word = word_of(rd_sel, cf2_word, cf3_word, tm_r[0], tm_r[1], seg_r[0], seg_r[1]);

	// ****************************************
	// AXI4-Lite write channels
	// ****************************************
	// address and data are taken in either order and held until the response
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 32'h0;
			w_data_r      <= 32'h0;
			w_strb_r      <= 4'h0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= MWP_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_r     <= 1'b1;
				aw_addr_r     <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_r     <= 1'b1;
				w_data_r     <= S_AXI_WDATA;
				w_strb_r     <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (wr_sel == MWP_REG_NONE) ? MWP_RESP_SLVERR : MWP_RESP_OKAY;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				aw_have_r     <= 1'b0;
				w_have_r      <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channels
	// ****************************************
	// data is sampled at the address handshake, one read in flight
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0;
			S_AXI_RRESP   <= MWP_RESP_OKAY;
			rd_sel_r      <= MWP_REG_NONE;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= rd_word;
				S_AXI_RRESP   <= (rd_sel == MWP_REG_NONE) ? MWP_RESP_SLVERR : MWP_RESP_OKAY;
				rd_sel_r      <= rd_sel;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// second config: only the refresh and sub-word bits live here
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			refresh_en_r <= 1'b0;
			sram_rmw_r   <= 1'b0;
		end else if (wr_fire && wr_sel == MWP_REG_CF2) begin
			refresh_en_r <= wr_word[MWP_CF2_REFRESH_BIT];
			sram_rmw_r   <= wr_word[MWP_CF2_RMW_BIT];
		end
	end

	// third config; strap caught on the first edge after release
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			reload_r     <= MWP_RELOAD_RST;
			wb_r         <= 1'b0;
			rb_r         <= 1'b0;
			re_r         <= 1'b0;
			pe_r         <= 1'b0;
			strap_done_r <= 1'b0;
		end else begin
			if (wr_fire && wr_sel == MWP_REG_CF3) begin
				reload_r <= wr_word[MWP_CF3_RELOAD_LO +: MWP_RELOAD_W];
				wb_r     <= wr_word[MWP_CF3_WB_BIT];
				rb_r     <= wr_word[MWP_CF3_RB_BIT];
				re_r     <= wr_word[MWP_CF3_RE_BIT];
				pe_r     <= wr_word[MWP_CF3_PE_BIT];
			end
			if (!strap_done_r) begin
				pe_r         <= PROM_EDAC_STRAP;
				strap_done_r <= 1'b1;
			end
		end
	end

	// capture beats a software write in the same cycle, the written checkbits are dropped
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tcb_r <= MWP_TCB_RST;
		end else if (ACC.valid && !ACC.write && rb_r) begin
			tcb_r <= CHECK_RD;
		end else if (wr_fire && wr_sel == MWP_REG_CF3) begin
			tcb_r <= wr_word[MWP_TCB_W-1:0];
		end
	end

	// protection unit registers; reserved bits are simply not stored
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < MWP_UNITS; i++) begin
				tm_r[i]  <= '0;
				seg_r[i] <= '0;
			end
		end else if (wr_fire) begin
			unique case (wr_sel)
				MWP_REG_TM1: tm_r[0] <= mwp_tagmask_s'(wr_word);
				MWP_REG_TM2: tm_r[1] <= mwp_tagmask_s'(wr_word);
				MWP_REG_S1A: begin
					seg_r[0].first              <= wr_word[29:2];
					seg_r[0].block_guard_select <= wr_word[1];
				end
				MWP_REG_S1B: begin
					seg_r[0].last               <= wr_word[29:2];
					seg_r[0].unprivileged_guard <= wr_word[1];
					seg_r[0].privileged_guard   <= wr_word[0];
				end
				MWP_REG_S2A: begin
					seg_r[1].first              <= wr_word[29:2];
					seg_r[1].block_guard_select <= wr_word[1];
				end
				MWP_REG_S2B: begin
					seg_r[1].last               <= wr_word[29:2];
					seg_r[1].unprivileged_guard <= wr_word[1];
					seg_r[1].privileged_guard   <= wr_word[0];
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// write protection checks
	// ****************************************
	logic [MWP_UNITS-1:0] tm_hit;
	logic [MWP_UNITS-1:0] tm_blk;
	logic [MWP_UNITS-1:0] seg_in;
	logic [MWP_UNITS-1:0] seg_act;
	logic [MWP_UNITS-1:0] seg_blk;
	logic                 blocked;

	// purely combinational so the verdict is ready in the access cycle
	for (genvar g = 0; g < MWP_UNITS; g++) begin : g_unit
		assign tm_hit[g]  = ((tm_r[g].tag ^ ACC.addr[29:15]) & tm_r[g].mask) == 15'h0;
		assign tm_blk[g]  = tm_r[g].en & (tm_r[g].block_guard_select ? tm_hit[g] : ~tm_hit[g]);
		assign seg_in[g]  = (ACC.addr[29:2] >= seg_r[g].first) && (ACC.addr[29:2] <= seg_r[g].last);
		assign seg_act[g] = ACC.privilege_state_bit ? seg_r[g].privileged_guard
			: seg_r[g].unprivileged_guard;
		assign seg_blk[g] = seg_act[g] & (seg_r[g].block_guard_select ? seg_in[g] : ~seg_in[g]);
	end

	assign blocked = ACC.write & ((|tm_blk) | (|seg_blk));

	// ****************************************
	// access answer
	// ****************************************
	// answer one cycle after the request; a blocked store never strobes memory
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACC_DONE  <= 1'b0;
			ACC_ERROR <= 1'b0;
			MEM_WE    <= 1'b0;
			CHECK_WR  <= MWP_TCB_RST;
			CHECK_EN  <= 1'b0;
		end else begin
			ACC_DONE  <= ACC.valid;
			ACC_ERROR <= ACC.valid & blocked;
			MEM_WE    <= ACC.valid & ACC.write & ~blocked;
			CHECK_WR  <= wb_r ? tcb_r : CHECK_CALC;
			CHECK_EN  <= ACC.prom ? pe_r : re_r;
		end
	end

	// enables seen by the memory sequencer
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RAM_EDAC_EN  <= 1'b0;
			PROM_EDAC_EN <= 1'b0;
			SRAM_RMW_EN  <= 1'b0;
			SDRAM_RMW_EN <= 1'b0;
		end else begin
			RAM_EDAC_EN  <= re_r;
			PROM_EDAC_EN <= pe_r;
			SRAM_RMW_EN  <= sram_rmw_r;
			SDRAM_RMW_EN <= re_r;
		end
	end

	// ****************************************
	// refresh timer
	// ****************************************
	// counter idles at the reload value while refresh is off
	logic [MWP_RELOAD_W-1:0] ref_cnt_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_cnt_r     <= MWP_RELOAD_RST;
			REFRESH_PULSE <= 1'b0;
		end else if (!refresh_en_r) begin
			ref_cnt_r     <= reload_r;
			REFRESH_PULSE <= 1'b0;
		end else if (ref_cnt_r == '0) begin
			ref_cnt_r     <= reload_r;
			REFRESH_PULSE <= 1'b1;
		end else begin
			ref_cnt_r     <= ref_cnt_r - 1'b1;
			REFRESH_PULSE <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_rfc_field_value: assert property (
		S_AXI_RVALID && rd_sel_r == MWP_REG_CF3 |-> S_AXI_RDATA[31:30] == MWP_RFC_SEVEN)
		else $error("checkbit count field not 11");
	a_present_bit_read: assert property (
		S_AXI_RVALID && rd_sel_r == MWP_REG_CF3 |-> S_AXI_RDATA[MWP_CF3_PRESENT_BIT] == CHECK_PRESENT)
		else $error("presence bit wrong");
	a_refresh_at_zero: assert property (
		refresh_en_r && ref_cnt_r == '0 |=> REFRESH_PULSE && ref_cnt_r == $past(reload_r))
		else $error("refresh not issued at terminal count");
	a_refresh_gated_off: assert property (
		!refresh_en_r |=> !REFRESH_PULSE)
		else $error("refresh while disabled");
	a_bypass_checkbits: assert property (
		ACC.valid && ACC.write && wb_r |=> CHECK_WR == $past(tcb_r))
		else $error("bypass checkbits not used");
	a_capture_checkbits: assert property (
		ACC.valid && !ACC.write && rb_r |=> tcb_r == $past(CHECK_RD))
		else $error("read checkbits not captured");
	a_blocked_no_store: assert property (
		ACC.valid && blocked |=> ACC_ERROR && ACC_DONE && !MEM_WE)
		else $error("blocked write reached memory");
	a_tag_block_mode: assert property (
		ACC.valid && ACC.write && tm_r[0].en && tm_r[0].block_guard_select && tm_hit[0] |=> ACC_ERROR)
		else $error("tag match not blocked");
	a_strap_load: assert property (
		$rose(strap_done_r) |-> pe_r == $past(PROM_EDAC_STRAP))
		else $error("strap not loaded");
	a_sdram_follows_ram: assert property (
		$rose(re_r) |=> RAM_EDAC_EN && SDRAM_RMW_EN)
		else $error("sub-word handling not enabled with RAM checking");

	c_blocked_write: cover property (ACC.valid && ACC.write && blocked);
	c_refresh_pulse: cover property (REFRESH_PULSE);
	c_capture_read:  cover property (ACC.valid && !ACC.write && rb_r);
	c_bus_write:     cover property (S_AXI_BVALID && S_AXI_BREADY);

endmodule

// [tb/mwp_cpu_model.sv]
`timescale 1ns/1ns
// ****************************************
// processor side: one memory access at a time
// ****************************************
module mwp_cpu_model
	import mwp_pkg::*;
(
	input  wire logic                 CLK,
	output mwp_acc_s                  ACC,
	output logic [MWP_TCB_W-1:0]      CHECK_CALC,
	output logic [MWP_TCB_W-1:0]      CHECK_RD
);
	logic [MWP_TCB_W-1:0] calc_seen;
	logic [MWP_TCB_W-1:0] rd_seen;

	// quiet bus at time zero
	initial begin
		ACC = '0;
		CHECK_CALC = '0;
		CHECK_RD = '0;
	end

	// checkbit lines change every cycle so a stale value never passes
	always @(posedge CLK) begin
		calc_seen <= CHECK_CALC;
		rd_seen <= CHECK_RD;
		CHECK_CALC <= 8'($urandom);
		CHECK_RD <= 8'($urandom);
	end

	// one-cycle request; returns just after the answering edge
	task automatic access(input logic wr, input logic sup, input logic prom, input logic [31:0] a);
		ACC <= '{valid: 1'b1, write: wr, privilege_state_bit: sup, prom: prom, addr: a};
		@(posedge CLK);
		ACC.valid <= 1'b0;
		#1;
	endtask
endmodule

// [tb/test_memory_write_protect_edac.sv]
`timescale 1ns/1ns
module test_memory_write_protect_edac
	import mwp_pkg::*;
;
	// ****************************************
	// signals and instances
	// ****************************************
	logic        clk, rst_n, strap, awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] awaddr, wdata, araddr;
	wire logic   awready, wready, bvalid, arready, rvalid, done, err, we;
	wire logic   chk_en, ram_en, prom_en, sram_rmw, sdram_rmw, refr;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  chk_wr, calc, rd;
	wire mwp_acc_s    acc;
	int          error_cnt, n_compared;
	logic [31:0] shadow [8];
	localparam logic [31:0] ADR [8] = '{MWP_OFF_CFG_SECOND, MWP_OFF_CFG_THIRD, MWP_OFF_TAGMASK1,
		MWP_OFF_TAGMASK2, MWP_OFF_SEG1_START, MWP_OFF_SEG1_END, MWP_OFF_SEG2_START, MWP_OFF_SEG2_END};
	localparam logic [31:0] WM [8] = '{32'h8000_0040, 32'h07ff_ffff, 32'hffff_ffff, 32'hffff_ffff,
		32'h3fff_fffe, 32'h3fff_ffff, 32'h3fff_fffe, 32'h3fff_ffff};

	mwp_guard dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ACC(acc), .CHECK_CALC(calc),
		.CHECK_RD(rd), .PROM_EDAC_STRAP(strap), .ACC_DONE(done), .ACC_ERROR(err), .MEM_WE(we),
		.CHECK_WR(chk_wr), .CHECK_EN(chk_en), .RAM_EDAC_EN(ram_en), .PROM_EDAC_EN(prom_en),
		.SRAM_RMW_EN(sram_rmw), .SDRAM_RMW_EN(sdram_rmw), .REFRESH_PULSE(refr));
	mwp_cpu_model cpu (.CLK(clk), .ACC(acc), .CHECK_CALC(calc), .CHECK_RD(rd));

	// 100 ns clock
	always #50 clk = ~clk;

	// ****************************************
	// compare, bus and reference tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// bready stays high throughout, so a later call never re-drives it at the same step
	// no cycle count assumed: only the watchdog ends a wait for the answer
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		r = rresp;
		d = rdata;
	endtask

	task automatic reg_wr(input int i, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(ADR[i], d, r);
		chk("bresp", MWP_RESP_OKAY, 32'(r));
		shadow[i] = d & WM[i];
	endtask

	task automatic reg_rd(input int i);
		logic [1:0]  r;
		logic [31:0] d;
		axi_rd(ADR[i], d, r);
		chk("rresp", MWP_RESP_OKAY, 32'(r));
		chk("reg_data", (i == 1) ? (shadow[1] | 32'hc800_0000) : shadow[i], d);
	endtask

	task automatic out_chk();
		chk("ram_edac_en", 32'(shadow[1][9]), 32'(ram_en));
		chk("sdram_rmw_en", 32'(shadow[1][9]), 32'(sdram_rmw));
		chk("prom_edac_en", 32'(shadow[1][8]), 32'(prom_en));
		chk("sram_rmw_en", 32'(shadow[0][6]), 32'(sram_rmw));
	endtask

	// reset, then every register and enable shows its reset or strap value
	task automatic reset_check(input int cyc);
		rst_n <= 1'b0;
		repeat (cyc) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (shadow[i]) shadow[i] = 32'h0;
		shadow[1] = (32'(MWP_RELOAD_RST) << MWP_CF3_RELOAD_LO) | (32'(strap) << MWP_CF3_PE_BIT);
		for (int i = 0; i < 8; i++) reg_rd(i);
		out_chk();
	endtask

	function automatic logic blocked(input logic [31:0] a, input logic s);
		logic b, m, in;
		logic [31:0] t, st, en;
		b = 1'b0;
		for (int u = 0; u < 2; u++) begin
			t = shadow[2+u];
			m = ((t[29:15] ^ a[29:15]) & t[14:0]) == 15'h0;
			if (t[31]) b |= t[30] ? m : !m;
			st = shadow[4+2*u];
			en = shadow[5+2*u];
			in = (st[29:2] <= a[29:2]) && (a[29:2] <= en[29:2]);
			if (s ? en[0] : en[1]) b |= st[1] ? in : !in;
		end
		return b;
	endfunction

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	// hang guard, well beyond the roughly 1700 cycles the run needs
	initial begin
		#3000000;
		error_cnt++;
		stop_test();
	end

	initial begin
		logic [31:0] base, a, v, d;
		logic [1:0]  r;
		logic        wr, s, p, bl;
		int          n;
		clk = 0; strap = 1; awvalid = 0; wvalid = 0; arvalid = 0;
		bready = 1; rready = 1; awaddr = 0; wdata = 0; araddr = 0;
		error_cnt = 0; n_compared = 0;
		void'($urandom(32'h936ebdec));
		reset_check(8);
		for (int i = 0; i < 8; i++) begin
			reg_wr(i, $urandom);
			reg_rd(i);
		end
		axi_wr(32'h8000_0024, 32'hffff_ffff, r);
		chk("unmapped_bresp", MWP_RESP_SLVERR, 32'(r));
		axi_rd(32'h8000_0024, d, r);
		chk("unmapped_rresp", MWP_RESP_SLVERR, 32'(r));
		chk("unmapped_rdata", 32'h0, d);
		// random guard setups, each probed by accesses around one base address
		for (int k = 0; k < 40; k++) begin
			base = $urandom;
			reg_wr(0, 32'h0000_0040);
			reg_wr(1, $urandom);
			for (int u = 0; u < 2; u++) begin
				v = $urandom;
				v[29:15] = base[29:15] ^ 15'($urandom_range(0, 7));
				reg_wr(2 + u, v);
				v = {2'b00, base[29:2] + 28'($urandom_range(0, 7)), 1'($urandom), 1'b0};
				reg_wr(4 + 2 * u, v);
				reg_wr(5 + 2 * u, {2'b00, v[29:2] + 28'($urandom_range(0, 7)), 2'($urandom)});
			end
			out_chk();
			repeat (6) begin
				a = base + 32'($urandom_range(0, 20)) * 4 - 32'd16;
				wr = 1'($urandom);
				s = 1'($urandom);
				p = 1'($urandom);
				bl = wr && blocked(a, s);
				cpu.access(wr, s, p, a);
				chk("acc_done", 32'h1, 32'(done));
				chk("acc_error", 32'(bl), 32'(err));
				chk("mem_we", 32'(wr && !bl), 32'(we));
				chk("check_en", 32'(p ? shadow[1][8] : shadow[1][9]), 32'(chk_en));
				chk("check_wr", 32'(shadow[1][11] ? shadow[1][7:0] : cpu.calc_seen), 32'(chk_wr));
				if (!wr && shadow[1][10]) shadow[1][7:0] = cpu.rd_seen;
				@(posedge clk);
			end
			reg_rd(1);
		end
		// refresh spacing with a short reload
		reg_wr(1, 32'h0000_5000);
		reg_wr(0, 32'h8000_0000);
		n = 0;
		while (!refr && n < 100) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!refr && n < 100);
		chk("refresh_gap", 32'(shadow[1][26:12]) + 32'd1, 32'(n));
		reg_wr(0, 32'h0);
		repeat (2) @(posedge clk);
		n = 0;
		repeat (20) begin
			@(posedge clk);
			if (refr !== 1'b0) n++;
		end
		chk("refresh_off", 32'h0, 32'(n));
		// second reset with the other strap level, so the strap really decides
		strap <= ~strap;
		reset_check(2);
		stop_test();
	end
endmodule
